// *** shared/aac_pkg.sv ***
/*
 * Constants of the converter sequencer: register map, field layout,
 * reset values and conversion timing.
 * Assumes a 32-bit Avalon-MM slave with byte addresses, one word each.
 */
`default_nettype none

package aac_pkg;

   // Register byte offsets
   localparam logic [4:0] AAC_OFS_CTRL0  = 5'h00;
   localparam logic [4:0] AAC_OFS_CTRL1  = 5'h04;
   localparam logic [4:0] AAC_OFS_ANCFG  = 5'h08;
   localparam logic [4:0] AAC_OFS_DIR    = 5'h0c;
   localparam logic [4:0] AAC_OFS_PORT   = 5'h10;
   localparam logic [4:0] AAC_OFS_RESULT = 5'h14;
   localparam logic [4:0] AAC_OFS_STATUS = 5'h18;
   localparam logic [4:0] AAC_OFS_MASK   = 5'h1c;

   // Field positions
   localparam int AAC_GO_BIT     = 0;
   localparam int AAC_CHS_LSB    = 2;
   localparam int AAC_CONV_CLK_SEL_LSB   = 0;
   localparam int AAC_ACQ_TIME_SEL_LSB   = 3;
   localparam int AAC_MODE12_BIT = 7;
   localparam int AAC_DONE_BIT   = 0;

   // Widths and reset values
   localparam int              AAC_NPIN      = 13;
   localparam logic [12:0]     AAC_ANCFG_RST = 13'h1fff;
   localparam logic [12:0]     AAC_DIR_RST   = 13'h1fff;
   localparam logic [2:0]      AAC_ACQ_TIME_SEL_RST  = 3'h0;
   localparam logic [2:0]      AAC_CONV_CLK_SEL_RST  = 3'h0;

   // Conversion length in bit periods and first trial bit per mode
   localparam logic [3:0]  AAC_TADS_10B = 4'd11;
   localparam logic [3:0]  AAC_TADS_12B = 4'd13;
   localparam logic [11:0] AAC_MSB_10B  = 12'h0200;
   localparam logic [11:0] AAC_MSB_12B  = 12'h0800;

   typedef enum logic [1:0] {AAC_IDLE, AAC_ACQ, AAC_CONV} aac_state_t;

   // Bit period in oscillator cycles; zero means the RC source
   function automatic logic [6:0] aac_tad_div(input logic [2:0] sel);
      case (sel)
         3'h0: aac_tad_div = 7'd2;
         3'h4: aac_tad_div = 7'd4;
         3'h1: aac_tad_div = 7'd8;
         3'h5: aac_tad_div = 7'd16;
         3'h2: aac_tad_div = 7'd32;
         3'h6: aac_tad_div = 7'd64;
         default: aac_tad_div = 7'd0;
      endcase
   endfunction : aac_tad_div

   // Programmed acquisition length in bit periods
   function automatic logic [4:0] aac_acq_tads(input logic [2:0] sel);
      case (sel)
         3'h1: aac_acq_tads = 5'd2;
         3'h2: aac_acq_tads = 5'd4;
         3'h3: aac_acq_tads = 5'd6;
         3'h4: aac_acq_tads = 5'd8;
         3'h5: aac_acq_tads = 5'd12;
         3'h6: aac_acq_tads = 5'd16;
         3'h7: aac_acq_tads = 5'd20;
         default: aac_acq_tads = 5'd0;
      endcase
   endfunction : aac_acq_tads

endpackage : aac_pkg

`default_nettype wire

// *** hw/aac_adc_ctrl.sv ***
/*
 * Acquisition and conversion sequencer of a successive-approximation
 * converter, with its register file, analog pin control and interrupt.
 * Assumes an external mux, hold switch, DAC and comparator driven by
 * channelSel, holdConnect and dacCode, and a free-running RC clock pin.
 */
// Notes on behaviour
// - Acquisition field zero: convert bit stops sampling and converts at once.
// - Acquisition field nonzero: keep sampling for that period, then convert.
// - At conversion end clear convert bit, set done flag, resume sampling.
// - No status separates acquisition from conversion; convert bit stays set.
// - Hold capacitor disconnected from the pin for the whole conversion.
// - Conversion takes 11 bit periods at 10 bits, 13 at 12 bits.
// - Clock select picks 2/4/8/16/32/64 oscillator periods or RC.
// - Conversion ignores analog-config and direction bits; converts selected level.
// - An output-configured analog pin converts its own driven level.
// - Port reads return zero for every analog-configured pin.
`timescale 1ns/1ps
`default_nettype none

module aac_adc_ctrl
   import aac_pkg::*;
(
   input  wire logic              ref_clk,
   input  wire logic              rst_b,
   input  wire logic [4:0]        avs_address,
   input  wire logic              avs_read,
   input  wire logic              avs_write,
   input  wire logic [31:0]       avs_writedata,
   output logic      [31:0]       avs_readdata,
   output logic                   avs_waitrequest,
   input  wire logic              rcClkIn,
   input  wire logic              compHigh,
   input  wire logic [12:0]       pinIn,
   output logic      [12:0]       pinOut,
   output logic      [12:0]       pinOe,
   output logic      [3:0]        channelSel,
   output logic                   holdConnect,
   output logic      [11:0]       dacCode,
   output logic                   irq
);

   aac_state_t  state;
   aac_state_t  next_state;
   logic        compS1;
   logic        rcS1;
   logic        rcS2;
   logic        rcS3;
   logic [12:0] pinS1;
   logic [12:0] pinS2;
   logic        goBit;
   logic        next_goBit;
   logic [2:0]  clkSel;
   logic [2:0]  next_clkSel;
   logic [2:0]  acqSel;
   logic [2:0]  next_acqSel;
   logic        mode12;
   logic        next_mode12;
   logic [12:0] anaCfg;
   logic [12:0] next_anaCfg;
   logic [12:0] pinDir;
   logic [12:0] next_pinDir;
   logic [12:0] next_pinOut;
   logic [3:0]  next_channelSel;
   logic        doneFlag;
   logic        next_doneFlag;
   logic        doneMask;
   logic        next_doneMask;
   logic [11:0] result;
   logic [11:0] next_result;
   logic [31:0] next_readdata;
   logic        next_waitrequest;
   logic [6:0]  divCnt;
   logic [6:0]  next_divCnt;
   logic [3:0]  tadCnt;
   logic [3:0]  next_tadCnt;
   logic [4:0]  acqCnt;
   logic [4:0]  next_acqCnt;
   logic [11:0] bitMask;
   logic [11:0] next_bitMask;
   logic [11:0] next_dacCode;
   logic        next_holdConnect;
   logic        wrAcc;
   logic        goWrite;
   logic        tadTick;
   logic        doneEv;
   logic [6:0]  tadDiv;

   // Pin inputs pass two stages, RC three; logic reads only pinS2 and the RC edge from rcS2 and rcS3.
   // The comparator answers our own registered DAC code, so one register is
   // enough; a second would lag one decision behind at divide-by-two
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         compS1 <= 1'b0;
         rcS1   <= 1'b0;
         rcS2   <= 1'b0;
         rcS3   <= 1'b0;
         pinS1  <= '0;
         pinS2  <= '0;
      end else begin
         compS1 <= compHigh;
         rcS1   <= rcClkIn;
         rcS2   <= rcS1;
         rcS3   <= rcS2;
         pinS1  <= pinIn;
         pinS2  <= pinS1;
      end
   end

   // A write takes effect at the edge where waitrequest is seen low
   assign wrAcc   = avs_write & ~avs_waitrequest;
   assign goWrite = wrAcc && (avs_address == AAC_OFS_CTRL0)
                    && avs_writedata[AAC_GO_BIT];

   // Bus answer, configuration registers and flags
   always_comb begin
      next_waitrequest = !((avs_read || avs_write) && avs_waitrequest);
      next_readdata    = avs_readdata;
      next_clkSel      = clkSel;
      next_acqSel      = acqSel;
      next_mode12      = mode12;
      next_anaCfg      = anaCfg;
      next_pinDir      = pinDir;
      next_pinOut      = pinOut;
      next_channelSel  = channelSel;
      next_doneMask    = doneMask;
      if (avs_read && avs_waitrequest) begin
         next_readdata = 32'h0000_0000;
         if (avs_address == AAC_OFS_CTRL0) begin
            next_readdata[AAC_GO_BIT] = goBit;
            next_readdata[AAC_CHS_LSB +: 4] = channelSel;
         end else if (avs_address == AAC_OFS_CTRL1) begin
            next_readdata[AAC_CONV_CLK_SEL_LSB +: 3] = clkSel;
            next_readdata[AAC_ACQ_TIME_SEL_LSB +: 3] = acqSel;
            next_readdata[AAC_MODE12_BIT]    = mode12;
         end else if (avs_address == AAC_OFS_ANCFG) begin
            next_readdata[AAC_NPIN-1:0] = anaCfg;
         end else if (avs_address == AAC_OFS_DIR) begin
            next_readdata[AAC_NPIN-1:0] = pinDir;
         end else if (avs_address == AAC_OFS_PORT) begin
            next_readdata[AAC_NPIN-1:0] = pinS2 & ~anaCfg;
         end else if (avs_address == AAC_OFS_RESULT) begin
            next_readdata[11:0] = result;
         end else if (avs_address == AAC_OFS_STATUS) begin
            next_readdata[AAC_DONE_BIT] = doneFlag;
         end else if (avs_address == AAC_OFS_MASK) begin
            next_readdata[AAC_DONE_BIT] = doneMask;
         end
      end
      if (wrAcc) begin
         if (avs_address == AAC_OFS_CTRL0) begin
            next_channelSel = avs_writedata[AAC_CHS_LSB +: 4];
         end else if (avs_address == AAC_OFS_CTRL1) begin
            next_clkSel = avs_writedata[AAC_CONV_CLK_SEL_LSB +: 3];
            next_acqSel = avs_writedata[AAC_ACQ_TIME_SEL_LSB +: 3];
            next_mode12 = avs_writedata[AAC_MODE12_BIT];
         end else if (avs_address == AAC_OFS_ANCFG) begin
            next_anaCfg = avs_writedata[AAC_NPIN-1:0];
         end else if (avs_address == AAC_OFS_DIR) begin
            next_pinDir = avs_writedata[AAC_NPIN-1:0];
         end else if (avs_address == AAC_OFS_PORT) begin
            next_pinOut = avs_writedata[AAC_NPIN-1:0];
         end else if (avs_address == AAC_OFS_MASK) begin
            next_doneMask = avs_writedata[AAC_DONE_BIT];
         end
      end
      // set beats a write-one clear in the same cycle
      next_doneFlag = doneFlag;
      if (wrAcc && (avs_address == AAC_OFS_STATUS)
          && avs_writedata[AAC_DONE_BIT]) begin
         next_doneFlag = 1'b0;
      end
      if (doneEv) begin
         next_doneFlag = 1'b1;
      end
   end

   // bit period from oscillator divider or synchronised RC edge
   assign tadDiv  = aac_tad_div(clkSel);
   assign tadTick = (tadDiv == 7'd0) ? (rcS2 & ~rcS3)
                                     : (divCnt == tadDiv - 7'd1);

   // Sequencer: sampling, acquisition, successive approximation
   always_comb begin
      next_state       = state;
      next_goBit       = goBit;
      next_divCnt      = divCnt + 7'd1;
      next_tadCnt      = tadCnt;
      next_acqCnt      = acqCnt;
      next_bitMask     = bitMask;
      next_dacCode     = dacCode;
      next_holdConnect = holdConnect;
      next_result      = result;
      doneEv           = 1'b0;
      if (tadTick) begin
         next_divCnt = 7'd0;
      end
      case (state)
         AAC_IDLE: begin
            next_holdConnect = 1'b1;
            next_divCnt      = 7'd0;
            if (goWrite) begin
               next_goBit  = 1'b1;
               next_tadCnt = 4'd0;
               next_acqCnt = 5'd0;
               if (acqSel == AAC_ACQ_TIME_SEL_RST) begin
                  next_state       = AAC_CONV;
                  next_holdConnect = 1'b0;
               end else begin
                  next_state = AAC_ACQ;
               end
            end
         end
         AAC_ACQ: begin
            if (tadTick) begin
               next_acqCnt = acqCnt + 5'd1;
               if (acqCnt == aac_acq_tads(acqSel) - 5'd1) begin
                  next_state       = AAC_CONV;
                  next_holdConnect = 1'b0;
               end
            end
         end
         AAC_CONV: begin
            if (tadTick) begin
               next_tadCnt = tadCnt + 4'd1;
               if (tadCnt == 4'd0) begin
                  next_bitMask = mode12 ? AAC_MSB_12B : AAC_MSB_10B;
                  next_dacCode = next_bitMask;
               end else begin
                  // Comparator high keeps the trial bit
                  next_dacCode = compS1 ? dacCode : (dacCode & ~bitMask);
                  next_bitMask = bitMask >> 1;
                  if (tadCnt == (mode12 ? AAC_TADS_12B : AAC_TADS_10B) - 4'd1)
                  begin
                     next_result      = next_dacCode;
                     next_goBit       = 1'b0;
                     doneEv           = 1'b1;
                     next_holdConnect = 1'b1;
                     next_state       = AAC_IDLE;
                  end else begin
                     next_dacCode = next_dacCode | next_bitMask;
                  end
               end
            end
         end
         default: begin
            next_state = AAC_IDLE;
         end
      endcase
   end

   // All state and outputs registered
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         state           <= AAC_IDLE;
         goBit           <= 1'b0;
         clkSel          <= AAC_CONV_CLK_SEL_RST;
         acqSel          <= AAC_ACQ_TIME_SEL_RST;
         mode12          <= 1'b0;
         anaCfg          <= AAC_ANCFG_RST;
         pinDir          <= AAC_DIR_RST;
         pinOut          <= '0;
         pinOe           <= '0;
         channelSel      <= '0;
         doneFlag        <= 1'b0;
         doneMask        <= 1'b0;
         result          <= '0;
         avs_readdata    <= 32'h0000_0000;
         avs_waitrequest <= 1'b1;
         divCnt          <= '0;
         tadCnt          <= '0;
         acqCnt          <= '0;
         bitMask         <= '0;
         dacCode         <= '0;
         holdConnect     <= 1'b1;
         irq             <= 1'b0;
      end else begin
         state           <= next_state;
         goBit           <= next_goBit;
         clkSel          <= next_clkSel;
         acqSel          <= next_acqSel;
         mode12          <= next_mode12;
         anaCfg          <= next_anaCfg;
         pinDir          <= next_pinDir;
         pinOut          <= next_pinOut;
         // output pins stay driven during conversion
         pinOe           <= ~pinDir;
         channelSel      <= next_channelSel;
         doneFlag        <= next_doneFlag;
         doneMask        <= next_doneMask;
         result          <= next_result;
         avs_readdata    <= next_readdata;
         avs_waitrequest <= next_waitrequest;
         divCnt          <= next_divCnt;
         tadCnt          <= next_tadCnt;
         acqCnt          <= next_acqCnt;
         bitMask         <= next_bitMask;
         dacCode         <= next_dacCode;
         holdConnect     <= next_holdConnect;
         irq             <= doneFlag & doneMask;  // Level, one cycle behind flag
      end
   end

endmodule : aac_adc_ctrl

`default_nettype wire

// *** tb/aac_adc_ctrl_monitor.sv ***
/* Checker of the converter sequencer: bus handshake, timing, interrupt.
   Sees only the top ports; snoops register writes to know the setup. */
`timescale 1ns/1ps
`default_nettype none

module aac_adc_ctrl_monitor
   import aac_pkg::*;
(
   input wire logic        ref_clk,
   input wire logic        rst_b,
   input wire logic [4:0]  avs_address,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [31:0] avs_readdata,
   input wire logic        avs_waitrequest,
   input wire logic        holdConnect,
   input wire logic        irq
);
   logic [7:0]  ctrl1, next_ctrl1;
   logic [12:0] ancfg, next_ancfg;
   logic        maskBit, next_maskBit, wrAck, rdAck, rcSel;
   logic [11:0] lowCnt, next_lowCnt, goCnt, next_goCnt, div, acq_time_sel, tads;

   // Snooped setup; RC timing is not checked since its edges are async
   always_comb begin
      wrAck = avs_write && !avs_waitrequest;
      rdAck = avs_read && !avs_waitrequest;
      rcSel = ctrl1[1:0] == 2'h3;
      div = 12'h002 << {ctrl1[1:0], ctrl1[2]};
      acq_time_sel = (ctrl1[5:3] > 3'h4) ? 12'(ctrl1[5:3]) * 12'h004 - 12'h008
                                 : 12'(ctrl1[5:3]) * 12'h002;
      tads = ctrl1[7] ? 12'h00d : 12'h00b;
      next_ctrl1 = (wrAck && avs_address == AAC_OFS_CTRL1) ? avs_writedata[7:0] : ctrl1;
      next_ancfg = (wrAck && avs_address == AAC_OFS_ANCFG) ? avs_writedata[12:0] : ancfg;
      next_maskBit = (wrAck && avs_address == AAC_OFS_MASK) ? avs_writedata[0] : maskBit;
      next_goCnt = (wrAck && avs_address == AAC_OFS_CTRL0 && avs_writedata[0]) ? 12'h001
                                                                              : goCnt + 12'h001;
      next_lowCnt = holdConnect ? 12'h000 : lowCnt + 12'h001;
   end

   // Register the snooped state
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         ctrl1 <= 8'h00;
         ancfg <= AAC_ANCFG_RST;
         maskBit <= 1'b0;
         goCnt <= 12'h000;
         lowCnt <= 12'h000;
      end else begin
         ctrl1 <= next_ctrl1;
         ancfg <= next_ancfg;
         maskBit <= next_maskBit;
         goCnt <= next_goCnt;
         lowCnt <= next_lowCnt;
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_b);

   sequence s_req;
      (avs_read || avs_write) && avs_waitrequest;
   endsequence
   sequence s_ack;
      !avs_waitrequest;
   endsequence

   a_wait_one: assert property (s_req |=> s_ack)
      else $error("no answer one cycle after request");
   a_wait_pulse: assert property (s_ack |=> avs_waitrequest)
      else $error("waitrequest low too long");
   a_unmapped_zero: assert property (rdAck && avs_address[1:0] != 2'h0 |-> avs_readdata == '0)
      else $error("unmapped read not zero");
   a_acq_delay: assert property ($fell(holdConnect) && !rcSel |-> goCnt == acq_time_sel * div + 12'h001)
      else $error("sampling period wrong");
   a_conv_len: assert property ($rose(holdConnect) && !rcSel |-> lowCnt == tads * div)
      else $error("conversion length wrong");
   a_go_busy: assert property (rdAck && avs_address == AAC_OFS_CTRL0 && !holdConnect
                               |-> avs_readdata[0])
      else $error("go bit clear during conversion");
   a_port_zero: assert property (rdAck && avs_address == AAC_OFS_PORT
                                 |-> (avs_readdata[12:0] & ancfg) == '0)
      else $error("analog pin read nonzero");
   a_irq_mask: assert property (irq |-> $past(maskBit))
      else $error("interrupt while masked");
endmodule : aac_adc_ctrl_monitor

`default_nettype wire

// *** tb/aac_analog_model.sv ***
/* Model of the selected channel, hold capacitor and comparator.
   Assumes channel n sits on pin n; input level of channel n is n,5Ah. */
`timescale 1ns/1ps
`default_nettype none

module aac_analog_model
   import aac_pkg::*;
(
   input  wire logic [3:0]  channelSel,
   input  wire logic        holdConnect,
   input  wire logic [11:0] dacCode,
   input  wire logic [12:0] pinOut,
   input  wire logic [12:0] pinOe,
   output logic             compHigh
);
   logic [11:0] pinLvl;
   logic [11:0] held;

   // a driven pin presents its own logic level
   always_comb begin
      if (pinOe[channelSel])
         pinLvl = pinOut[channelSel] ? 12'hfff : 12'h000;
      else
         pinLvl = {channelSel, 8'h5a};
   end

   // cap tracks only while connected, then holds
   always @(holdConnect or pinLvl) begin
      if (holdConnect)
         held = pinLvl;
   end

   // Half-step offset keeps every decision away from a tie
   assign compHigh = {held, 1'b1} > {dacCode, 1'b0};
endmodule : aac_analog_model

`default_nettype wire

// *** tb/tb_top.sv ***
/* Self-checking bench of the converter sequencer, one task per scenario.
   Assumes the analog model on the far side and an async RC clock. */
`timescale 1ns/1ps
`default_nettype none

module tb_top
   import aac_pkg::*;
;
   logic        ref_clk, rst_b, avs_read, avs_write, avs_waitrequest, rcClk;
   logic        compHigh, holdConnect, irq, mskOn;
   logic [4:0]  avs_address;
   logic [31:0] avs_writedata, avs_readdata, q;
   logic [12:0] pinOut, pinOe, pinIn;
   logic [3:0]  channelSel;
   logic [11:0] dacCode;
   int          miscompares, checksDone;

   // Input pins float high, driven pins show the latch
   assign pinIn = pinOut | ~pinOe;

   aac_adc_ctrl aac_adc_ctrl_i (.ref_clk(ref_clk), .rst_b(rst_b), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .rcClkIn(rcClk),
      .compHigh(compHigh), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe),
      .channelSel(channelSel), .holdConnect(holdConnect), .dacCode(dacCode), .irq(irq));

   aac_analog_model aac_analog_model_i (.channelSel(channelSel), .holdConnect(holdConnect),
      .dacCode(dacCode), .pinOut(pinOut), .pinOe(pinOe), .compHigh(compHigh));

   task automatic summarize();
      $display("checks %0d miscompares %0d", checksDone, miscompares);
      if (miscompares == 0 && checksDone > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : summarize

   task automatic fail(input string m);
      miscompares++;
      $display("Error %0t: %s", $time, m);
   endtask : fail

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      checksDone++;
      if (got !== exp)
         fail(m);
   endtask : chk

   // One bus access; held until waitrequest is sampled low
   task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
      int n;
      @(posedge ref_clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= w;
      avs_read <= !w;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      if (n >= 50) begin
         fail("bus timeout");
         summarize();
      end
   endtask : bus

   // Select, settle, start, wait for go to drop, then judge the outcome
   task automatic conv(input logic [3:0] ch, input logic [11:0] exp);
      int n;
      bus(1'b1, AAC_OFS_CTRL0, 32'({ch, 2'b00}));
      repeat (4) @(posedge ref_clk);
      bus(1'b1, AAC_OFS_CTRL0, 32'({ch, 2'b01}));
      n = 0;
      do begin
         bus(1'b0, AAC_OFS_CTRL0, 32'h0000_0000);
         n++;
      end while (q[0] !== 1'b0 && n < 2000);
      if (n >= 2000) begin
         fail("conversion hang");
         summarize();
      end
      chk(q, 32'({ch, 2'b00}), "control after end");
      bus(1'b0, AAC_OFS_RESULT, 32'h0000_0000);
      chk(q, 32'(exp), "result");
      bus(1'b0, AAC_OFS_STATUS, 32'h0000_0000);
      chk(q, 32'h0000_0001, "done flag");
      chk(32'(irq), 32'(mskOn), "irq level");
      bus(1'b1, AAC_OFS_STATUS, 32'h0000_0001);
      repeat (2) @(posedge ref_clk);
      chk(32'(irq), 32'h0000_0000, "irq after clear");
      bus(1'b0, AAC_OFS_STATUS, 32'h0000_0000);
      chk(q, 32'h0000_0000, "flag after clear");
   endtask : conv

   task automatic t_regs();
      logic [4:0]  adr [9];
      logic [12:0] val [9];
      adr = '{AAC_OFS_CTRL0, AAC_OFS_CTRL1, AAC_OFS_ANCFG, AAC_OFS_DIR, AAC_OFS_RESULT,
              AAC_OFS_STATUS, AAC_OFS_MASK, AAC_OFS_PORT, 5'h1d};
      val = '{13'h0000, 13'h0000, AAC_ANCFG_RST, AAC_DIR_RST, 13'h0000, 13'h0000, 13'h0000,
              13'h0000, 13'h0000};
      for (int i = 0; i < 9; i++) begin
         bus(1'b0, adr[i], 32'h0000_0000);
         chk(q, 32'(val[i]), "reset value");
      end
      $display("test reset values done");
   endtask : t_regs

   // Every clock source in 10-bit mode, no programmed sampling
   task automatic t_clk();
      for (int s = 0; s < 8; s++) begin
         bus(1'b1, AAC_OFS_CTRL1, 32'(s));
         conv(4'h2, 12'h25a);
      end
      $display("test clock select done");
   endtask : t_clk

   // Every programmed sampling length in 12-bit mode
   task automatic t_acq();
      for (int a = 1; a < 8; a++) begin
         bus(1'b1, AAC_OFS_CTRL1, 32'h0000_0080 | 32'(a << 3));
         conv(4'h9, 12'h95a);
      end
      $display("test sampling length done");
   endtask : t_acq

   task automatic t_pin();
      bus(1'b1, AAC_OFS_CTRL1, 32'h0000_0080);
      bus(1'b1, AAC_OFS_DIR, 32'h0000_1ffd);
      bus(1'b1, AAC_OFS_PORT, 32'h0000_0002);
      conv(4'h1, 12'hfff);
      bus(1'b1, AAC_OFS_PORT, 32'h0000_0000);
      conv(4'h1, 12'h000);
      bus(1'b1, AAC_OFS_DIR, 32'(AAC_DIR_RST));
      $display("test output pin done");
   endtask : t_pin

   task automatic t_port();
      bus(1'b1, AAC_OFS_ANCFG, 32'h0000_00ff);
      bus(1'b0, AAC_OFS_PORT, 32'h0000_0000);
      chk(q, 32'h0000_1f00, "port read");
      bus(1'b1, AAC_OFS_ANCFG, 32'(AAC_ANCFG_RST));
      $display("test port read done");
   endtask : t_port

   task automatic t_irq();
      mskOn = 1'b1;
      bus(1'b1, AAC_OFS_MASK, 32'h0000_0001);
      conv(4'h3, 12'h35a);
      mskOn = 1'b0;
      bus(1'b1, AAC_OFS_MASK, 32'h0000_0000);
      $display("test interrupt done");
   endtask : t_irq

   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end

   // RC source, unrelated in phase to the system clock
   initial begin
      rcClk = 1'b0;
      forever #685 rcClk = ~rcClk;
   end

   initial begin
      rst_b = 1'b0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_address = 5'h00;
      avs_writedata = 32'h0000_0000;
      mskOn = 1'b0;
      miscompares = 0;
      checksDone = 0;
      repeat (8) @(posedge ref_clk);
      rst_b <= 1'b1;
      t_regs();
      t_clk();
      t_acq();
      t_pin();
      t_port();
      t_irq();
      summarize();
   end
endmodule : tb_top

bind aac_adc_ctrl aac_adc_ctrl_monitor aac_adc_ctrl_monitor_i (.ref_clk(ref_clk),
   .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
   .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest), .holdConnect(holdConnect), .irq(irq));

`default_nettype wire
